/* logic/wkt_pkg.sv */
// Constants of the wake-up countdown timer: register map, fields, reset values, timing.
// Assumes a 100 MHz reference clock and a 32-bit Avalon-MM register port.
// Function
// - Clearing pause resumes from held count.
// - Pause set freezes the countdown.
// - Power-domain select overrides the pause bit.
// - Global stop halts slow source clocks.
// - Run bit clear means no counting.
// - Counting starts at link clock rising edge.
// - Zero preset gives no expiry events.
// - Interval equals preset times source period.
// - Reload preset after every expiry.
// - Only run rising edge loads preset.
// - Count reads give preset or live value.
// - Event flag sticky, cleared by writing zero.
// - Interrupt enable gates the open-drain pin.
package wkt_pkg;
    // Byte offsets of the registers
    localparam logic [4:0] OFF_PRESET   = 5'h00;
    localparam logic [4:0] OFF_CTRL     = 5'h04;
    localparam logic [4:0] OFF_FLAG     = 5'h08;
    localparam logic [4:0] OFF_COUNT    = 5'h0C;
    localparam logic [4:0] OFF_IRQ_STAT = 5'h10;
    localparam logic [4:0] OFF_IRQ_CLR  = 5'h14;
    localparam logic [4:0] OFF_IRQ_EN   = 5'h18;
    // Control register fields
    localparam int CTRL_PAUSE   = 0;
    localparam int CTRL_RUN     = 1;
    localparam int CTRL_PDS     = 2;
    localparam int CTRL_BATT    = 3;
    localparam int CTRL_SEL_LO  = 4;
    localparam int CTRL_SEL_HI  = 5;
    localparam int CTRL_STOP    = 6;
    localparam int CTRL_TIE     = 7;
    // Flag and interrupt status fields
    localparam int FLAG_TIMER   = 0;
    localparam int IRQ_EXPIRE   = 0;
    localparam int IRQ_START    = 1;
    // Reset values
    localparam logic [7:0]  CTRL_RST   = 8'h00;
    localparam logic [23:0] PRESET_RST = 24'h000000;
    localparam logic [1:0]  IRQ_RST    = 2'h0;
    // Timing: reference clock and the fastest source clock period
    localparam int CLK_PERIOD_NS     = 10;
    localparam int SRC_4096_PERIOD_NS = 244_140;
    localparam int DIV_4096_CYC      = SRC_4096_PERIOD_NS / CLK_PERIOD_NS;
    // Source clock ratios
    localparam int TICKS_PER_64HZ    = 64;
    localparam int TICKS_PER_1HZ     = 4096;
    localparam int SEC_PER_MIN       = 60;
    // Source clock selection codes
    localparam logic [1:0] SEL_4096 = 2'h0;
    localparam logic [1:0] SEL_64   = 2'h1;
    localparam logic [1:0] SEL_1    = 2'h2;
    localparam logic [1:0] SEL_MIN  = 2'h3;
    // Countdown sequencer states
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_ARMED = 3'b010,
        ST_COUNT = 3'b100
    } wkt_state_e;
endpackage

/* logic/wkt_timer.sv */
// Wake-up countdown timer with Avalon-MM register port and open-drain interrupt pin.
// Assumes SCL_I and ON_BATTERY_I are asynchronous pins; all logic runs on REF_CLK_I.
//
// The Avalon-MM slave port and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module wkt_timer
    import wkt_pkg::*;
#(
    parameter int DIV_CYC = DIV_4096_CYC    // Reference cycles per 4096 Hz tick
) (
    // Clock and reset
    input  wire logic        REF_CLK_I,
    input  wire logic        RESETN_I,
    // Avalon-MM slave
    input  wire logic [4:0]  AVS_ADDRESS_I,
    input  wire logic        AVS_READ_I,
    input  wire logic        AVS_WRITE_I,
    input  wire logic [31:0] AVS_WRITEDATA_I,
    input  wire logic [3:0]  AVS_BYTEENABLE_I,
    output logic      [31:0] AVS_READDATA_O,
    output logic             AVS_WAITREQUEST_O,
    // Link and power pins
    input  wire logic        SCL_I,
    input  wire logic        ON_BATTERY_I,
    // Open-drain timer interrupt pin
    output logic             TMR_INT_N_O,
    output logic             TMR_INT_N_OE_N_O,
    // System interrupt
    output logic             IRQ_O
);

    // Register hit for a byte address, word aligned
    function automatic logic hit(input logic [4:0] addr, input logic [4:0] off);
        hit = (addr[4:2] == off[4:2]);
    endfunction

    // Byte-lane merge of a write into an old value
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        merge = res;
    endfunction

    localparam int DW = $clog2(DIV_CYC + 1);           // Prescaler width
    localparam logic [DW-1:0] DIV_LAST = DW'(DIV_CYC - 1);

    // Synchronisers for the pins
    logic [1:0]  scl_sync;                             // Link clock sync chain
    logic        scl_prev;                             // Previous synced link clock
    logic [1:0]  bat_sync;                             // Battery domain sync chain
    logic        scl_rise;                             // Link clock rising edge
    // Bus state
    logic        ack, next_ack;                        // Answer cycle marker
    logic [31:0] rdata, next_rdata;                    // Registered read data
    // Software state
    logic [7:0]  ctrl, next_ctrl;                      // Control bits
    logic [23:0] preset, next_preset;                  // Countdown preset
    logic        flag, next_flag;                      // Timer event flag
    logic        int_low, next_int_low;                // Pin pulled low
    logic [1:0]  irq_stat, next_irq_stat;              // Sticky interrupt status
    logic [1:0]  irq_en, next_irq_en;                  // Interrupt enables
    // Prescaler state
    logic [DW-1:0] div_cnt, next_div_cnt;              // Reference cycle divider
    logic [11:0] sub_cnt, next_sub_cnt;                // 4096 Hz tick counter
    logic [5:0]  min_cnt, next_min_cnt;                // Second counter
    logic        src_tick;                             // Selected source tick
    // Countdown state
    wkt_state_e  st, next_st;                          // Sequencer state
    logic [23:0] count, next_count;                    // Live count
    logic        expire;                               // Expiry in this cycle
    logic        start;                                // Count start in this cycle
    // Decoded bus access
    logic        take;                                 // Request in its answer cycle
    logic        wr_ctrl;                              // Control write taken
    logic        run_rise;                             // Run bit goes from 0 to 1
    assign take     = (AVS_READ_I | AVS_WRITE_I) & ack;
    assign wr_ctrl  = take & AVS_WRITE_I & hit(AVS_ADDRESS_I, OFF_CTRL);
    assign run_rise = wr_ctrl & next_ctrl[CTRL_RUN] & ~ctrl[CTRL_RUN];
    assign scl_rise = scl_sync[1] & ~scl_prev;
    // Pin synchronisers and link edge finder
    always_ff @(posedge REF_CLK_I) begin
        if (!RESETN_I) begin
            scl_sync <= 2'h3;                  // Idle level of the pulled-up pin
            scl_prev <= 1'b1;                  // No false edge after reset
            bat_sync <= 2'h0;
        end else begin
            scl_sync <= {scl_sync[0], SCL_I};
            scl_prev <= scl_sync[1];
            bat_sync <= {bat_sync[0], ON_BATTERY_I};
        end
    end

    // Bus answer: one wait state, read data ready with waitrequest low
    always_comb begin
        next_ack   = (AVS_READ_I | AVS_WRITE_I) & ~ack;
        next_rdata = 32'h00000000;
        if (hit(AVS_ADDRESS_I, OFF_PRESET)) begin
            next_rdata = {8'h00, preset};
        end else if (hit(AVS_ADDRESS_I, OFF_CTRL)) begin
            next_rdata = {24'h000000, ctrl};
        end else if (hit(AVS_ADDRESS_I, OFF_FLAG)) begin
            next_rdata = {31'h00000000, flag};
        end else if (hit(AVS_ADDRESS_I, OFF_COUNT)) begin
            next_rdata = {8'h00, ctrl[CTRL_RUN] ? count : preset};
        end else if (hit(AVS_ADDRESS_I, OFF_IRQ_STAT)) begin
            next_rdata = {30'h00000000, irq_stat};
        end else if (hit(AVS_ADDRESS_I, OFF_IRQ_EN)) begin
            next_rdata = {30'h00000000, irq_en};
        end
    end

    // Bus registers
    always_ff @(posedge REF_CLK_I) begin
        if (!RESETN_I) begin
            ack   <= 1'b0;
            rdata <= 32'h00000000;
        end else begin
            ack   <= next_ack;
            rdata <= next_rdata;
        end
    end

    // Software registers, flags and interrupt pin latch
    always_comb begin
        logic [31:0] m;
        m             = 32'h00000000;
        next_ctrl     = ctrl;
        next_preset   = preset;
        next_flag     = flag;
        next_irq_en   = irq_en;
        next_irq_stat = irq_stat;
        if (take && AVS_WRITE_I) begin
            if (hit(AVS_ADDRESS_I, OFF_PRESET)) begin
                m           = merge({8'h00, preset}, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
                next_preset = m[23:0];
            end else if (hit(AVS_ADDRESS_I, OFF_CTRL)) begin
                m         = merge({24'h000000, ctrl}, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
                next_ctrl = m[7:0];
            end else if (hit(AVS_ADDRESS_I, OFF_FLAG)) begin
                // Zero clears, one is ignored
                if (AVS_BYTEENABLE_I[0] && !AVS_WRITEDATA_I[FLAG_TIMER]) begin
                    next_flag = 1'b0;
                end
            end else if (hit(AVS_ADDRESS_I, OFF_IRQ_CLR)) begin
                if (AVS_BYTEENABLE_I[0]) begin
                    next_irq_stat = irq_stat & ~AVS_WRITEDATA_I[1:0];
                end
            end else if (hit(AVS_ADDRESS_I, OFF_IRQ_EN)) begin
                if (AVS_BYTEENABLE_I[0]) begin
                    next_irq_en = AVS_WRITEDATA_I[1:0];
                end
            end
        end
        // Hardware set wins over a clear in the same cycle
        if (expire) begin
            next_flag = 1'b1;
        end
        next_irq_stat[IRQ_EXPIRE] = next_irq_stat[IRQ_EXPIRE] | expire;
        next_irq_stat[IRQ_START]  = next_irq_stat[IRQ_START] | start;
        // Pin stays low until the enable is cleared
        next_int_low = ctrl[CTRL_TIE] & (int_low | expire);
    end
    // Software register storage
    always_ff @(posedge REF_CLK_I) begin
        if (!RESETN_I) begin
            ctrl     <= CTRL_RST;
            preset   <= PRESET_RST;
            flag     <= 1'b0;
            int_low  <= 1'b0;
            irq_stat <= IRQ_RST;
            irq_en   <= IRQ_RST;
        end else begin
            ctrl     <= next_ctrl;
            preset   <= next_preset;
            flag     <= next_flag;
            int_low  <= next_int_low;
            irq_stat <= next_irq_stat;
            irq_en   <= next_irq_en;
        end
    end

    // Source clock prescaler; global stop holds the slow stages
    always_comb begin
        logic tick;
        logic run_slow;
        tick         = (div_cnt == DIV_LAST);
        run_slow     = tick & ~ctrl[CTRL_STOP];
        next_div_cnt = tick ? '0 : div_cnt + DW'(1);
        next_sub_cnt = run_slow ? sub_cnt + 12'h001 : sub_cnt;
        next_min_cnt = min_cnt;
        if (run_slow && sub_cnt == 12'(TICKS_PER_1HZ - 1)) begin
            next_min_cnt = (min_cnt == 6'(SEC_PER_MIN - 1)) ? 6'h00 : min_cnt + 6'h01;
        end
        // One source period per count
        case ({ctrl[CTRL_SEL_HI], ctrl[CTRL_SEL_LO]})
            SEL_4096: src_tick = tick;
            SEL_64:   src_tick = run_slow && sub_cnt[5:0] == 6'(TICKS_PER_64HZ - 1);
            SEL_1:    src_tick = run_slow && sub_cnt == 12'(TICKS_PER_1HZ - 1);
            default:  src_tick = run_slow && sub_cnt == 12'(TICKS_PER_1HZ - 1)
                                 && min_cnt == 6'(SEC_PER_MIN - 1);
        endcase
    end
    // Prescaler storage
    always_ff @(posedge REF_CLK_I) begin
        if (!RESETN_I) begin
            div_cnt <= '0;
            sub_cnt <= 12'h000;
            min_cnt <= 6'h00;
        end else begin
            div_cnt <= next_div_cnt;
            sub_cnt <= next_sub_cnt;
            min_cnt <= next_min_cnt;
        end
    end

    // Countdown sequencer
    always_comb begin
        logic count_en;
        // Power-domain select overrides pause
        count_en   = ctrl[CTRL_PDS] ? (bat_sync[1] == ctrl[CTRL_BATT])
                                    : ~ctrl[CTRL_PAUSE];
        next_st    = st;
        next_count = count;
        expire     = 1'b0;
        start      = 1'b0;
        case (st)
            ST_IDLE: begin
                // Only a run rising edge loads the preset
                if (run_rise) begin
                    next_st    = ST_ARMED;
                    next_count = preset;
                end
            end
            ST_ARMED: begin
                if (!next_ctrl[CTRL_RUN]) begin
                    next_st = ST_IDLE;
                end else if (scl_rise) begin
                    next_st = ST_COUNT;
                    start   = 1'b1;
                end
            end
            ST_COUNT: begin
                if (!next_ctrl[CTRL_RUN]) begin
                    next_st = ST_IDLE;
                end else if (src_tick && count_en && preset != 24'h000000) begin
                    if (count <= 24'h000001) begin
                        expire     = 1'b1;
                        next_count = preset;
                    end else begin
                        next_count = count - 24'h000001;
                    end
                end
            end
            default: begin
                next_st = ST_IDLE;
            end
        endcase
    end
    // Countdown storage
    always_ff @(posedge REF_CLK_I) begin
        if (!RESETN_I) begin
            st    <= ST_IDLE;
            count <= PRESET_RST;
        end else begin
            st    <= next_st;
            count <= next_count;
        end
    end
    // Outputs
    assign AVS_READDATA_O    = rdata;
    assign AVS_WAITREQUEST_O = (AVS_READ_I | AVS_WRITE_I) & ~ack;
    assign TMR_INT_N_O       = 1'b0;
    assign TMR_INT_N_OE_N_O  = ~int_low;
    assign IRQ_O             = |(irq_stat & irq_en);
    // Checks
    property p_pause_freeze;
        @(posedge REF_CLK_I) disable iff (!RESETN_I)
        (st == ST_COUNT && ctrl[CTRL_PAUSE] && !ctrl[CTRL_PDS] && !wr_ctrl) |=> $stable(count);
    endproperty
    a_pause_freeze: assert property (p_pause_freeze) else $error("moved in pause");
    // Only a pause that really froze the count must resume from the held value
    property p_resume_held;
        @(posedge REF_CLK_I) disable iff (!RESETN_I)
        (st == ST_COUNT && $fell(ctrl[CTRL_PAUSE]) && $past(st) == ST_COUNT
         && !$past(ctrl[CTRL_PDS])) |-> count == $past(count);
    endproperty
    a_resume_held: assert property (p_resume_held) else $error("resume reloaded");
    property p_pds_counts;
        @(posedge REF_CLK_I) disable iff (!RESETN_I)
        (st == ST_COUNT && ctrl[CTRL_PDS] && ctrl[CTRL_PAUSE] && bat_sync[1] == ctrl[CTRL_BATT]
         && src_tick && count > 24'h000001 && !wr_ctrl) |=> count == $past(count) - 24'h000001;
    endproperty
    a_pds_counts: assert property (p_pds_counts) else $error("pause not overridden");
    property p_stop_slow;
        @(posedge REF_CLK_I) disable iff (!RESETN_I)
        (ctrl[CTRL_STOP] && {ctrl[CTRL_SEL_HI], ctrl[CTRL_SEL_LO]} != SEL_4096) |-> !src_tick;
    endproperty
    a_stop_slow: assert property (p_stop_slow) else $error("slow tick under stop");
    property p_no_run;
        @(posedge REF_CLK_I) disable iff (!RESETN_I)
        !ctrl[CTRL_RUN] |-> (st == ST_IDLE && !expire);
    endproperty
    a_no_run: assert property (p_no_run) else $error("counting without run");
    property p_start_edge;
        @(posedge REF_CLK_I) disable iff (!RESETN_I)
        (st == ST_ARMED && next_ctrl[CTRL_RUN]) |-> (scl_rise ##1 st == ST_COUNT) or
            (!scl_rise ##1 st == ST_ARMED);
    endproperty
    a_start_edge: assert property (p_start_edge) else $error("start not on link edge");
    property p_zero_preset;
        @(posedge REF_CLK_I) disable iff (!RESETN_I)
        preset == 24'h000000 |-> !expire;
    endproperty
    a_zero_preset: assert property (p_zero_preset) else $error("event with zero preset");
    property p_reload;
        @(posedge REF_CLK_I) disable iff (!RESETN_I)
        (expire && !wr_ctrl) |=> (count == $past(preset) && flag);
    endproperty
    a_reload: assert property (p_reload) else $error("no reload or flag on expiry");
    property p_pin;
        @(posedge REF_CLK_I) disable iff (!RESETN_I)
        (expire && ctrl[CTRL_TIE]) |=> !TMR_INT_N_OE_N_O;
    endproperty
    a_pin: assert property (p_pin) else $error("interrupt pin not pulled low");
    // Clearing the enable releases the pin on the next cycle
    property p_pin_free;
        @(posedge REF_CLK_I) disable iff (!RESETN_I)
        !ctrl[CTRL_TIE] |=> TMR_INT_N_OE_N_O;
    endproperty
    a_pin_free: assert property (p_pin_free) else $error("interrupt pin not released");
endmodule
`default_nettype wire

/* testbench/wkt_host_link.sv */
// Host end of the two-wire link: clocks out one byte frame on request.
// Assumes GO is a one-cycle pulse; SCL idles high by pull-up between frames.
`timescale 1ns/10ps
`default_nettype none
module wkt_host_link (
    // Frame request from the bench
    input  wire logic go_i,
    // Link clock, 160 ns period inside frames
    output logic      scl_o
);
    // Pulled-up idle level
    initial scl_o = 1'b1;
    // Eight data clocks then the acknowledge clock
    always @(posedge go_i) begin
        repeat (9) begin
            #80 scl_o <= 1'b0;
            #80 scl_o <= 1'b1;
        end
    end
endmodule
`default_nettype wire

/* testbench/testbench.sv */
// Self-checking bench of the wake-up timer over its register port.
// Assumes the host link model drives SCL; prescaler shortened to DIV.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import wkt_pkg::*;
    localparam int DIV = 4;                    // Cycles per fast tick
    localparam logic [31:0] B_PAUSE = 32'h1 << CTRL_PAUSE;
    localparam logic [31:0] B_RUN   = 32'h1 << CTRL_RUN;
    localparam logic [31:0] B_PDS   = 32'h1 << CTRL_PDS;
    localparam logic [31:0] B_STOP  = 32'h1 << CTRL_STOP;
    localparam logic [31:0] B_TIE   = 32'h1 << CTRL_TIE;
    localparam logic [31:0] B_SEL64 = 32'(SEL_64) << CTRL_SEL_LO;
    localparam logic [31:0] B_SEL1  = 32'(SEL_1) << CTRL_SEL_LO;
    localparam logic [31:0] B_SELMN = 32'(SEL_MIN) << CTRL_SEL_LO;
    logic        ref_clk = 1'b0;                // Bench clock
    logic        resetn  = 1'b0;                // Reset, active low
    logic        rd = 1'b0, wr = 1'b0;           // Bus strobes
    logic [4:0]  adr = 5'h00;                   // Bus address
    logic [31:0] wdat = 32'h0, rdat, readdata;   // Bus data
    logic        waitreq, int_n, int_oe_n, irq; // Design outputs
    logic        scl, go = 1'b0, on_batt = 1'b0; // Link and power pins
    logic [31:0] c3;                            // Held count
    int          bad_count = 0, n_tests = 0, cyc = 0, g;
    // Clock and cycle counter
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) cyc <= cyc + 1;
    wkt_timer #(.DIV_CYC(DIV)) dut_u (
        .REF_CLK_I(ref_clk), .RESETN_I(resetn), .AVS_ADDRESS_I(adr),
        .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdat),
        .AVS_BYTEENABLE_I(4'hF), .AVS_READDATA_O(readdata),
        .AVS_WAITREQUEST_O(waitreq), .SCL_I(scl), .ON_BATTERY_I(on_batt),
        .TMR_INT_N_O(int_n), .TMR_INT_N_OE_N_O(int_oe_n), .IRQ_O(irq));
    wkt_host_link host_u (.go_i(go), .scl_o(scl));
    // Verdict and end of run
    task automatic end_sim;
        if (bad_count == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Compare one value
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // One bus cycle, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        adr <= a;
        wdat <= d;
        wr <= w;
        rd <= ~w;
        do begin
            @(posedge ref_clk);
            n++;
        end while (waitreq !== 1'b0 && n < 50);
        if (n >= 50) check(32'h0, 32'h1);
        rdat = readdata;
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(rdat, exp);
    endtask
    // Wait for the interrupt, bounded
    task automatic wait_irq(output int t);
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 20000) begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= 20000) check(32'h0, 32'h1);
        t = cyc;
    endtask
    // One link frame, then settle
    task automatic frame;
        go <= 1'b1;
        @(posedge ref_clk);
        go <= 1'b0;
        wait_cyc(160);
    endtask
    // Stop, load preset, clear events, enable
    task automatic arm(input logic [31:0] p, input logic [31:0] c);
        bus(1'b1, OFF_CTRL, 32'h0);
        bus(1'b1, OFF_PRESET, p);
        bus(1'b1, OFF_IRQ_CLR, 32'h3);
        bus(1'b1, OFF_CTRL, c | B_RUN);
    endtask
    // Cycles between two expiries; one expiry first aligns the clears
    task automatic gap(output int d);
        int t0, t1;
        bus(1'b1, OFF_IRQ_CLR, 32'h1);
        wait_cyc(2);
        wait_irq(t0);
        bus(1'b1, OFF_IRQ_CLR, 32'h1);
        wait_cyc(2);
        wait_irq(t0);
        bus(1'b1, OFF_IRQ_CLR, 32'h1);
        wait_cyc(2);
        wait_irq(t1);
        d = t1 - t0;
    endtask
    // Reset values and refused accesses
    task automatic s_reset;
        rd_chk(OFF_CTRL, 32'(CTRL_RST));
        rd_chk(OFF_PRESET, 32'(PRESET_RST));
        rd_chk(OFF_IRQ_EN, 32'(IRQ_RST));
        check(32'(int_oe_n), 32'h1);
        bus(1'b1, 5'h1C, 32'hFFFFFFFF);
        rd_chk(5'h1C, 32'h0);
        bus(1'b1, OFF_COUNT, 32'h5);
        rd_chk(OFF_COUNT, 32'h0);
    endtask
    // Zero preset never expires
    task automatic s_zero;
        arm(32'h0, B_TIE);
        frame;
        rd_chk(OFF_FLAG, 32'h0);
        check(32'(int_oe_n), 32'h1);
    endtask
    // Start, period, flag and pin
    task automatic s_start;
        bus(1'b1, OFF_IRQ_EN, 32'h1);
        arm(32'h3, B_TIE | B_STOP);
        wait_cyc(40);
        rd_chk(OFF_COUNT, 32'h3);
        rd_chk(OFF_IRQ_STAT, 32'h0);
        frame;
        gap(g);
        check(32'(g), 32'(3 * DIV));
        bus(1'b1, OFF_CTRL, B_TIE);
        rd_chk(OFF_COUNT, 32'h3);
        check(32'({int_n, int_oe_n}), 32'h0);
        rd_chk(OFF_FLAG, 32'h1);
        bus(1'b1, OFF_FLAG, 32'h1);
        rd_chk(OFF_FLAG, 32'h1);
        bus(1'b1, OFF_FLAG, 32'h0);
        rd_chk(OFF_FLAG, 32'h0);
        check(32'(int_oe_n), 32'h0);
        bus(1'b1, OFF_CTRL, 32'h0);
        wait_cyc(2);
        check(32'(int_oe_n), 32'h1);
        rd_chk(OFF_IRQ_STAT, 32'h3);
        bus(1'b1, OFF_IRQ_EN, 32'h0);
        wait_cyc(2);
        check(32'(irq), 32'h0);
        bus(1'b1, OFF_IRQ_CLR, 32'h3);
        rd_chk(OFF_IRQ_STAT, 32'h0);
    endtask
    // Pause, resume, domain override, run off
    task automatic s_pause;
        arm(32'd1000, 32'h0);
        frame;
        bus(1'b1, OFF_CTRL, B_RUN | B_PAUSE);
        bus(1'b0, OFF_COUNT, 32'h0);
        c3 = rdat;
        wait_cyc(40);
        rd_chk(OFF_COUNT, c3);
        bus(1'b1, OFF_CTRL, B_RUN);
        wait_cyc(40);
        bus(1'b0, OFF_COUNT, 32'h0);
        check(32'(rdat < c3 - 8 && rdat > c3 - 16), 32'h1);
        bus(1'b1, OFF_CTRL, B_RUN | B_PAUSE | B_PDS);
        bus(1'b0, OFF_COUNT, 32'h0);
        c3 = rdat;
        wait_cyc(40);
        bus(1'b0, OFF_COUNT, 32'h0);
        check(32'(rdat != c3), 32'h1);
        on_batt <= 1'b1;
        wait_cyc(4);
        bus(1'b0, OFF_COUNT, 32'h0);
        c3 = rdat;
        wait_cyc(40);
        rd_chk(OFF_COUNT, c3);
        on_batt <= 1'b0;
        bus(1'b1, OFF_CTRL, B_PAUSE | B_PDS);
        rd_chk(OFF_COUNT, 32'd1000);
    endtask
    // Slow source period and global stop
    task automatic s_slow;
        bus(1'b1, OFF_IRQ_EN, 32'h1);
        arm(32'h1, B_SEL64);
        frame;
        gap(g);
        check(32'(g), 32'(TICKS_PER_64HZ * DIV));
        bus(1'b1, OFF_CTRL, B_RUN | B_SEL64 | B_STOP);
        bus(1'b1, OFF_IRQ_CLR, 32'h1);
        wait_cyc(600);
        check(32'(irq), 32'h0);
        bus(1'b1, OFF_CTRL, B_RUN | B_SELMN | B_STOP);
        wait_cyc(600);
        check(32'(irq), 32'h0);
        arm(32'h1, B_SEL1);
        frame;
        gap(g);
        check(32'(g), 32'(TICKS_PER_1HZ * DIV));
        bus(1'b1, OFF_CTRL, 32'h0);
    endtask
    // Main sequence
    initial begin
        wait_cyc(5);
        resetn <= 1'b1;
        wait_cyc(1);
        s_reset;
        s_zero;
        s_start;
        s_pause;
        s_slow;
        end_sim;
    end
    // Watchdog against a hang
    initial begin
        #700000;
        bad_count++;
        end_sim;
    end
endmodule
`default_nettype wire
